/* File: verilog/hsc_pkg.sv */
// Shared constants and types of the sensor configuration block
package hsc_pkg;

    localparam int CLK_NS        = 10;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_NS;
    localparam int GLITCH_NS     = 50;
    localparam int GLITCH_CYCLES = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int STEP_NS       = 1000;
    localparam int STEP_CYCLES   = (STEP_NS + CLK_NS - 1) / CLK_NS;

    // Bus address of this device; value is arbitrary
    localparam logic [6:0] DEV_ADDR     = 7'h35;
    localparam logic [7:0] OFFS_DEV_CFG = 8'h01;
    localparam logic [7:0] OFFS_CH_CFG  = 8'h02;
    localparam logic [7:0] RST_DEV_CFG  = 8'h00;
    localparam logic [7:0] RST_CH_CFG   = 8'h00;
    localparam logic [7:0] RD_UNMAPPED  = 8'h00;
    localparam int         TRIG_CMD_BIT = 7;
    localparam logic [3:0] BYTE_BITS    = 4'h8;
    localparam logic [8:0] HYST_BASE    = 9'h002;

    localparam logic [3:0] CH_NONE  = 4'h0;
    localparam logic [3:0] CH_XYX   = 4'h8;
    localparam logic [3:0] CH_DPOS  = 4'hC;
    localparam logic [3:0] CH_DNEG  = 4'hD;
    localparam logic [3:0] CH_HRES  = 4'hE;
    localparam logic [3:0] CH_HOFS  = 4'hF;

    typedef enum logic [1:0] {
        MODE_STANDBY = 2'h0,
        MODE_SLEEP   = 2'h1,
        MODE_CONT    = 2'h2,
        MODE_DUTY    = 2'h3
    } hsc_mode_t;

    typedef enum logic [1:0] {
        AX_X = 2'h0, AX_Y = 2'h1, AX_Z = 2'h2, AX_CHK = 2'h3
    } hsc_axis_t;

    typedef enum logic [2:0] {
        DG_NONE = 3'h0, DG_POS = 3'h1, DG_NEG = 3'h2,
        DG_RES  = 3'h3, DG_OFS = 3'h4
    } hsc_diag_t;

    typedef struct packed {
        logic [2:0] hyst;
        logic       low_noise;
        logic       glitch_off;
        logic       trig_pin;
        hsc_mode_t  mode;
    } hsc_dev_cfg_t;

    typedef struct packed {
        logic [3:0] chan;
        logic [3:0] sleep;
    } hsc_ch_cfg_t;

    typedef struct packed {
        logic      valid;
        hsc_axis_t axis;
        hsc_diag_t diag;
    } hsc_meas_t;

    function automatic logic [8:0] hyst_lsb(input logic [2:0] code);
        return HYST_BASE << code;
    endfunction

    // Reserved codes fall back to the longest interval
    function automatic logic [14:0] sleep_ms(input logic [3:0] code);
        case (code)
            4'h0: return 15'h0001;
            4'h1: return 15'h0005;
            4'h2: return 15'h000A;
            4'h3: return 15'h000F;
            4'h4: return 15'h0014;
            4'h5: return 15'h001E;
            4'h6: return 15'h0032;
            4'h7: return 15'h0064;
            4'h8: return 15'h01F4;
            4'h9: return 15'h03E8;
            4'hA: return 15'h07D0;
            4'hB: return 15'h1388;
            default: return 15'h4E20;
        endcase
    endfunction

endpackage

/* File: verilog/hsc_conv_seq.sv */
// Axis sequencer that steps through one conversion
`timescale 1ns/1ps
module hsc_conv_seq
    import hsc_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       rst_n_in,
    input  wire logic       start_in,
    input  wire logic [3:0] chan_sel_in,
    output logic            busy_out,
    output logic            done_out,
    output hsc_meas_t       meas_out
);

    logic [3:0] code;
    logic [1:0] step;
    logic [6:0] tick;

    // Packed as length, then first, second and third axis
    function automatic logic [7:0] seq_plan(input logic [3:0] c);
        case (c)
            4'h0: return 8'h00;
            4'h1: return 8'h40;
            4'h2: return 8'h50;
            4'h3: return 8'h84;
            4'h4: return 8'h60;
            4'h5: return 8'hA0;
            4'h6: return 8'h98;
            4'h7: return 8'hC6;
            4'h8: return 8'hC4;
            4'h9: return 8'hD1;
            4'hA: return 8'hD9;
            4'hB: return 8'hC8;
            4'hC: return 8'hC6;
            4'hD: return 8'hC6;
            default: return 8'h70;
        endcase
    endfunction

    wire [7:0]  plan_w = seq_plan(code);
    wire [1:0]  len_w  = plan_w[7:6];
    wire        last_w = (step == len_w);
    wire        tick_end_w = (tick == 7'(STEP_CYCLES - 1));
    wire [1:0]  ax_bits_w = (step == 2'h0) ? plan_w[5:4] :
                            (step == 2'h1) ? plan_w[3:2] : plan_w[1:0];
    wire hsc_diag_t diag_w = (code == CH_DPOS) ? DG_POS :
                             (code == CH_DNEG) ? DG_NEG :
                             (code == CH_HRES) ? DG_RES :
                             (code == CH_HOFS) ? DG_OFS : DG_NONE;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_out <= 1'b0;
            done_out <= 1'b0;
            code     <= CH_NONE;
            step     <= 2'h0;
            tick     <= 7'h00;
        end else begin
            done_out <= 1'b0;
            if (!busy_out) begin
                if (start_in) begin
                    busy_out <= 1'b1;
                    code     <= chan_sel_in;
                    step     <= 2'h0;
                    tick     <= 7'h00;
                end
            end else if (last_w) begin
                busy_out <= 1'b0;
                done_out <= 1'b1;
            end else if (tick_end_w) begin
                tick <= 7'h00;
                step <= step + 2'h1;
            end else begin
                tick <= tick + 7'h01;
            end
        end
    end

    // Lags the step state by one cycle
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meas_out <= '0;
        end else begin
            meas_out.valid <= busy_out && !last_w;
            meas_out.axis  <= hsc_axis_t'(ax_bits_w);
            meas_out.diag  <= diag_w;
        end
    end

    a_chan_off: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        start_in && !busy_out && chan_sel_in == CH_NONE
        |=> busy_out ##1 (done_out && !meas_out.valid))
        else $error("channel code zero still acquired an axis");

    a_seq_xyx: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        start_in && !busy_out && chan_sel_in == CH_XYX
        |=> ##1 (meas_out.valid && meas_out.axis == AX_X))
        else $error("repeated sequence did not open on X");

endmodule // hsc_conv_seq

/* File: verilog/hsc_config.sv */
// Mode, trigger and channel configuration logic with its serial port
`timescale 1ns/1ps
module hsc_config
    import hsc_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
) (
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_out,
    input  wire logic        alert_n_in,
    input  wire logic [11:0] sample_in,
    input  wire logic        sample_valid_in,
    input  wire logic [11:0] threshold_in,
    input  wire logic        switch_mode_in,
    output logic             low_noise_out,
    output hsc_mode_t        op_mode_out,
    output logic             conv_busy_out,
    output logic             conv_done_out,
    output hsc_meas_t        meas_out,
    output logic             switch_state_out
);

    typedef enum logic [2:0] {
        I2C_IDLE  = 3'h0,
        I2C_ADDR  = 3'h1,
        I2C_REG   = 3'h2,
        I2C_WDATA = 3'h3,
        I2C_RDATA = 3'h4
    } hsc_i2c_t;

    hsc_dev_cfg_t dev_cfg;
    hsc_ch_cfg_t  ch_cfg;

    // Pin synchronisers; index 1 is the clock line, 0 the data line
    logic [1:0] line_meta;
    logic [1:0] line_sync;
    logic [1:0] line_filt;
    logic [1:0] line_prev;
    logic [2:0] flt_cnt [2];
    logic       alert_meta;
    logic       alert_sync;
    logic       alert_prev;

    hsc_i2c_t   i2c_st;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic       ack_phase;
    logic       drive_low;

    logic        pend;
    logic        switch_state;
    logic [31:0] pre_cnt;
    logic [14:0] ms_cnt;
    logic        conv_busy;

    // Bus line conditions after filtering
    wire scl_f      = line_filt[1];
    wire sda_f      = line_filt[0];
    wire scl_prev   = line_prev[1];
    wire sda_prev   = line_prev[0];
    wire start_det  = scl_f && scl_prev && sda_prev && !sda_f;
    wire stop_det   = scl_f && scl_prev && !sda_prev && sda_f;
    wire scl_rise   = scl_f && !scl_prev;
    wire scl_fall   = !scl_f && scl_prev;
    wire addr_hit_w = (shreg[7:1] == DEV_ADDR);

    wire byte_done_w = scl_fall && !ack_phase && (bit_cnt == BYTE_BITS)
                       && !start_det && !stop_det;
    wire wr_en_w     = byte_done_w && (i2c_st == I2C_WDATA);
    wire wr_dev_w    = wr_en_w && (ptr == OFFS_DEV_CFG);
    wire wr_ch_w     = wr_en_w && (ptr == OFFS_CH_CFG);
    wire hsc_dev_cfg_t wr_cfg_w = hsc_dev_cfg_t'(shreg);

    wire [7:0] rd_data_w = (ptr == OFFS_DEV_CFG) ? 8'(dev_cfg) :
                           (ptr == OFFS_CH_CFG)  ? 8'(ch_cfg)  :
                           RD_UNMAPPED;

    // Conversion request sources
    wire cmd_trig_w = byte_done_w && (i2c_st == I2C_REG)
                      && shreg[TRIG_CMD_BIT];
    wire pin_trig_w = alert_prev && !alert_sync;
    wire is_standby = (dev_cfg.mode == MODE_STANDBY);
    wire is_cont    = (dev_cfg.mode == MODE_CONT);
    wire is_duty    = (dev_cfg.mode == MODE_DUTY);
    wire trig_evt_w = is_standby &&
                      (dev_cfg.trig_pin ? pin_trig_w : cmd_trig_w);

    // Duty-cycle sleep timer
    wire [14:0] sleep_len_w = sleep_ms(ch_cfg.sleep);
    wire        ms_tick_w   = (pre_cnt == 32'(MS_CYCLES_P - 1));
    wire        expire_w    = ms_tick_w && (ms_cnt == sleep_len_w - 15'h0001);

    wire start_std_w  = is_standby && pend && !conv_busy;
    wire start_cont_w = is_cont && !conv_busy;
    wire start_duty_w = is_duty && !conv_busy && expire_w;
    wire start_w      = start_std_w || start_cont_w || start_duty_w;

    // Switch comparator, all at 14 bits signed
    wire signed [13:0] samp_w = {{2{sample_in[11]}}, sample_in};
    wire signed [13:0] thr_w  = {{2{threshold_in[11]}}, threshold_in};
    wire [8:0] hyst_w = switch_mode_in ? hyst_lsb(dev_cfg.hyst) : 9'h000;
    wire signed [13:0] low_w = thr_w - $signed({5'h00, hyst_w});
    wire next_switch = (samp_w > thr_w) ? 1'b1 :
                       (samp_w < low_w) ? 1'b0 : switch_state;
    wire sw_change_w = sample_valid_in && (next_switch != switch_state);
    wire exit_duty_w = is_duty && sw_change_w;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            line_meta  <= 2'h3;
            line_sync  <= 2'h3;
            line_prev  <= 2'h3;
            alert_meta <= 1'b1;
            alert_sync <= 1'b1;
            alert_prev <= 1'b1;
        end else begin
            line_meta  <= {scl_in, sda_in};
            line_sync  <= line_meta;
            line_prev  <= line_filt;
            alert_meta <= alert_n_in;
            alert_sync <= alert_meta;
            alert_prev <= alert_sync;
        end
    end

    // A change passes once stable for the glitch time, or at once if bypassed
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            line_filt <= 2'h3;
            flt_cnt   <= '{3'h0, 3'h0};
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (line_sync[i] == line_filt[i]) begin
                    flt_cnt[i] <= 3'h0;
                end else if (dev_cfg.glitch_off ||
                             flt_cnt[i] == 3'(GLITCH_CYCLES - 1)) begin
                    line_filt[i] <= line_sync[i];
                    flt_cnt[i]   <= 3'h0;
                end else begin
                    flt_cnt[i] <= flt_cnt[i] + 3'h1;
                end
            end
        end
    end

    // Serial slave: bits taken on the rising clock edge, driven on falling
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            i2c_st    <= I2C_IDLE;
            bit_cnt   <= 4'h0;
            shreg     <= 8'h00;
            tx        <= 8'h00;
            ptr       <= 8'h00;
            ack_phase <= 1'b0;
            drive_low <= 1'b0;
        end else if (start_det) begin
            i2c_st    <= I2C_ADDR;
            bit_cnt   <= 4'h0;
            ack_phase <= 1'b0;
            drive_low <= 1'b0;
        end else if (stop_det) begin
            i2c_st    <= I2C_IDLE;
            ack_phase <= 1'b0;
            drive_low <= 1'b0;
        end else if (i2c_st != I2C_IDLE) begin
            if (scl_rise && !ack_phase) begin
                shreg   <= {shreg[6:0], sda_f};
                bit_cnt <= bit_cnt + 4'h1;
            end
            // Host NACK ends a read
            if (scl_rise && ack_phase && i2c_st == I2C_RDATA && sda_f) begin
                i2c_st <= I2C_IDLE;
            end
            if (scl_fall) begin
                if (ack_phase) begin
                    ack_phase <= 1'b0;
                    bit_cnt   <= 4'h0;
                    if (i2c_st == I2C_RDATA) begin
                        tx        <= rd_data_w;
                        drive_low <= !rd_data_w[7];
                        ptr       <= ptr + 8'h01;
                    end else begin
                        drive_low <= 1'b0;
                    end
                end else if (bit_cnt == BYTE_BITS) begin
                    ack_phase <= 1'b1;
                    unique case (i2c_st)
                        I2C_ADDR: begin
                            if (addr_hit_w) begin
                                drive_low <= 1'b1;
                                i2c_st    <= shreg[0] ? I2C_RDATA : I2C_REG;
                            end else begin
                                i2c_st <= I2C_IDLE;
                            end
                        end
                        I2C_REG: begin
                            drive_low <= 1'b1;
                            ptr       <= {1'b0, shreg[6:0]};
                            i2c_st    <= I2C_WDATA;
                        end
                        I2C_WDATA: begin
                            drive_low <= 1'b1;
                            ptr       <= ptr + 8'h01;
                        end
                        I2C_RDATA: begin
                            drive_low <= 1'b0;
                        end
                        default: begin
                            i2c_st <= I2C_IDLE;
                        end
                    endcase
                end else if (i2c_st == I2C_RDATA) begin
                    tx        <= {tx[6:0], 1'b0};
                    drive_low <= !tx[6];
                end
            end
        end
    end

    // Hardware exit from duty mode wins over a same-cycle write
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dev_cfg <= hsc_dev_cfg_t'(RST_DEV_CFG);
            ch_cfg  <= hsc_ch_cfg_t'(RST_CH_CFG);
        end else begin
            if (wr_dev_w) begin
                dev_cfg <= wr_cfg_w;
            end
            if (wr_ch_w) begin
                ch_cfg <= hsc_ch_cfg_t'(shreg);
            end
            if (exit_duty_w) begin
                dev_cfg.mode <= MODE_STANDBY;
            end
        end
    end

    // One pending trigger at most; extras are dropped
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend <= 1'b0;
        end else if (!is_standby) begin
            pend <= 1'b0;
        end else if (start_std_w) begin
            pend <= 1'b0;
        end else if (trig_evt_w) begin
            pend <= 1'b1;
        end
    end

    // Timer runs only while duty mode sleeps between conversions
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pre_cnt <= 32'h0000_0000;
            ms_cnt  <= 15'h0000;
        end else if (!is_duty || conv_busy || start_duty_w) begin
            pre_cnt <= 32'h0000_0000;
            ms_cnt  <= 15'h0000;
        end else if (ms_tick_w) begin
            pre_cnt <= 32'h0000_0000;
            ms_cnt  <= ms_cnt + 15'h0001;
        end else begin
            pre_cnt <= pre_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            switch_state <= 1'b0;
        end else if (sample_valid_in) begin
            switch_state <= next_switch;
        end
    end

    hsc_conv_seq u_seq (
        .mclk_in     (mclk_in),
        .rst_n_in    (rst_n_in),
        .start_in    (start_w),
        .chan_sel_in (ch_cfg.chan),
        .busy_out    (conv_busy),
        .done_out    (conv_done_out),
        .meas_out    (meas_out)
    );

    // Open drain: the line is only ever pulled low
    assign sda_out          = 1'b0;
    assign sda_oe_out       = drive_low;
    assign low_noise_out    = dev_cfg.low_noise;
    assign op_mode_out      = dev_cfg.mode;
    assign conv_busy_out    = conv_busy;
    assign switch_state_out = switch_state;

    a_hyst_two: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        switch_state && sample_valid_in && switch_mode_in &&
        dev_cfg.hyst == 3'h0 && samp_w == thr_w - 14'sh0002
        |=> switch_state)
        else $error("smallest hysteresis did not hold the switch");

    a_hyst_plain: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !switch_mode_in && sample_valid_in && samp_w < thr_w
        |=> !switch_state)
        else $error("hysteresis applied outside switch mode");

    a_noise_write: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        wr_dev_w |=> low_noise_out == $past(wr_cfg_w.low_noise))
        else $error("noise select did not follow the write");

    a_filter_bypass: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        dev_cfg.glitch_off && line_sync != line_filt
        |=> line_filt == $past(line_sync))
        else $error("bypassed filter still delayed the line");

    a_trig_wait: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        pend && conv_busy |-> !start_w)
        else $error("conversion restarted before the running one ended");

    a_trig_drop: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        pend && is_standby && conv_busy ##1 is_standby
        |-> pend)
        else $error("pending trigger lost while busy");

    a_trig_mode: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !is_standby |=> !pend)
        else $error("trigger kept outside standby");

    a_duty_exit: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        exit_duty_w |=> op_mode_out == MODE_STANDBY)
        else $error("mode field not updated on leaving duty mode");

    a_duty_idle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !is_duty |=> ms_cnt == 15'h0000 && pre_cnt == 32'h0000_0000)
        else $error("sleep timer ran outside duty mode");

endmodule // hsc_config

/* File: verif/hsc_host.sv */
// Bus master model for the serial configuration port
`timescale 1ns/1ps
module hsc_host (
    input  wire logic mclk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_oe_out
);
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    // Quarter bit of 4 cycles gives the 160 ns bus clock
    task automatic q(input int n);
        repeat (4 * n) @(posedge mclk_in);
    endtask
    task automatic start();
        sda_oe_out <= 1'b0;
        scl_out <= 1'b1;
        q(1);
        sda_oe_out <= 1'b1;
        q(1);
        scl_out <= 1'b0;
        q(1);
    endtask
    task automatic stop();
        sda_oe_out <= 1'b1;
        q(1);
        scl_out <= 1'b1;
        q(1);
        sda_oe_out <= 1'b0;
        q(2);
    endtask
    // Nine clocks; data only moves while the clock is low
    task automatic xfer(input logic [8:0] b, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_oe_out <= ~b[i];
            q(1);
            scl_out <= 1'b1;
            q(1);
            r[i] = sda_in;
            q(1);
            scl_out <= 1'b0;
            q(1);
        end
    endtask
endmodule // hsc_host

/* File: verif/testbench.sv */
// Self-checking bench of the sensor configuration block
`timescale 1ns/1ps
module testbench;
    import hsc_pkg::*;
    localparam int MSP = 10;
    logic        mclk = 1'b0, rst_n = 1'b0, alert_n = 1'b1, sv = 1'b0;
    logic        scl, host_oe, dut_oe, lown, sw, busy, done, swm = 1'b0;
    logic        watch = 1'b0, pv = 1'b0;
    logic [11:0] smp = 12'h000, h;
    hsc_mode_t   mode;
    hsc_meas_t   meas;
    logic [13:0] expq[$], e;
    logic [1:0]  pa, fa;
    logic [3:0]  n = 4'h0;
    logic [3:0]  m = 4'h0;
    logic [2:0]  dg = 3'h0;
    logic [7:0]  r;
    logic [8:0]  x;
    int          miscompares = 0, compares = 0, cyc = 0, g0, g2;
    wire         sda = ~(host_oe | dut_oe);
    wire         sdo;
    always #5 mclk = ~mclk;
    hsc_host host (.mclk_in(mclk), .sda_in(sda), .scl_out(scl),
        .sda_oe_out(host_oe));
    hsc_config #(.MS_CYCLES_P(MSP)) dut (
        .mclk_in(mclk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sdo), .sda_oe_out(dut_oe), .alert_n_in(alert_n),
        .sample_in(smp), .sample_valid_in(sv), .threshold_in(12'h000),
        .switch_mode_in(swm), .low_noise_out(lown), .op_mode_out(mode),
        .conv_busy_out(busy), .conv_done_out(done), .meas_out(meas),
        .switch_state_out(sw));
    task automatic cmp(input string s, input logic [15:0] ex,
                       input logic [15:0] g);
        compares++;
        if (g !== ex) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", s, ex, g);
        end
    endtask
    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d,
                      input logic wd);
        host.start();
        host.xfer({DEV_ADDR, 2'b01}, x);
        cmp("ack", 16'h0, x[0]);
        host.xfer({p, 1'b1}, x);
        if (wd) host.xfer({d, 1'b1}, x);
        host.stop();
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] ex);
        wr(p, 8'h00, 1'b0);
        host.start();
        host.xfer({DEV_ADDR, 2'b11}, x);
        host.xfer(9'h1FF, x);
        host.stop();
        cmp("read", ex, x[8:1]);
    endtask
    task automatic samp(input logic [11:0] v);
        smp <= v;
        sv <= 1'b1;
        tick(1);
        sv <= 1'b0;
        tick(3);
    endtask
    task automatic alrt(input int k);
        repeat (k) begin
            alert_n <= 1'b0;
            tick(4);
            alert_n <= 1'b1;
            tick(6);
        end
    endtask
    task automatic gap(input logic [3:0] c, output int g);
        int t;
        wr(8'h02, {4'h1, c}, 1'b1);
        repeat (2) @(posedge busy);
        t = cyc;
        @(posedge busy);
        g = cyc - t;
    endtask
    // Record: diag, first-axis care bit, steps, axis set, first axis
    function automatic logic [13:0] exp_of(input logic [3:0] c);
        case (c)
            4'h8: return {DG_NONE, 1'b1, 4'h3, 4'h3, AX_X};
            4'h9: return {DG_NONE, 1'b1, 4'h3, 4'h3, AX_Y};
            4'hA: return {DG_NONE, 1'b1, 4'h3, 4'h6, AX_Y};
            4'hB: return {DG_NONE, 1'b1, 4'h3, 4'h5, AX_X};
            4'hC: return {DG_POS, 1'b0, 4'h3, 4'h7, 2'h0};
            4'hD: return {DG_NEG, 1'b0, 4'h3, 4'h7, 2'h0};
            4'hE: return {DG_RES, 1'b0, 4'h1, 4'h8, 2'h0};
            4'hF: return {DG_OFS, 1'b0, 4'h1, 4'h8, 2'h0};
            default: return {DG_NONE, 1'b0,
                             4'(c[0]) + 4'(c[1]) + 4'(c[2]),
                             {1'b0, c[2:0]}, 2'h0};
        endcase
    endfunction
    always @(posedge mclk) begin
        if (watch && done === 1'b1) begin
            if (expq.size() == 0) cmp("extra conversion", 16'h0, 16'h1);
            else begin
                e = expq.pop_front();
                cmp("conversion", e,
                    {dg, e[10], n, m, e[10] ? fa : e[1:0]});
            end
            n = 4'h0;
            m = 4'h0;
            dg = 3'h0;
        end
        if (meas.valid === 1'b1) dg = meas.diag;
        if (meas.valid === 1'b1 && (pv !== 1'b1 || meas.axis !== pa)) begin
            if (n == 4'h0) fa = meas.axis;
            n++;
            m[meas.axis] = 1'b1;
        end
        pv = meas.valid;
        pa = meas.axis;
    end
    always @(posedge mclk) if (++cyc == 80000) begin
        miscompares++;
        close_out();
    end
    initial begin
        void'($urandom(66));
        tick(6);
        rst_n <= 1'b1;
        tick(4);
        rd(8'h01, RST_DEV_CFG);
        rd(8'h02, RST_CH_CFG);
        rd(8'h03, RD_UNMAPPED);
        host.start();
        host.xfer({~DEV_ADDR, 2'b01}, x);
        host.stop();
        cmp("foreign address", 16'h1, x[0]);
        r = 8'($urandom) & 8'hF8;
        wr(8'h01, r, 1'b1);
        cmp("low noise", r[4], lown);
        rd(8'h01, r);
        cmp("data value", 16'h0, sdo);
        h = 12'h002 << r[7:5];
        swm <= 1'b1;
        samp(12'h001);
        cmp("switch", 16'h1, sw);
        samp(12'h000 - h);
        cmp("switch", 16'h1, sw);
        samp(12'hFFF - h);
        cmp("switch", 16'h0, sw);
        swm <= 1'b0;
        samp(12'h001);
        samp(12'hFFF);
        cmp("switch", 16'h0, sw);
        wr(8'h01, 8'h00, 1'b1);
        watch <= 1'b1;
        for (int c = 0; c < 16; c++) begin
            wr(8'h02, {4'(c), 4'h0}, 1'b1);
            expq.push_back(exp_of(4'(c)));
            wr(8'h82, 8'h00, 1'b0);
            wait (expq.size() == 0);
            tick(4);
        end
        wr(8'h02, 8'h10, 1'b1);
        wr(8'h01, 8'h04, 1'b1);
        repeat (2) expq.push_back(exp_of(4'h1));
        alrt(3);
        wait (expq.size() == 0);
        tick(300);
        wr(8'h82, 8'h00, 1'b0);
        tick(300);
        wr(8'h01, 8'h05, 1'b1);
        alrt(1);
        tick(300);
        watch <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            wr(8'h01, 8'(k), 1'b1);
            cmp("mode", k, mode);
        end
        gap(4'h0, g0);
        gap(4'h2, g2);
        cmp("sleep gap", 9 * MSP, g2 - g0);
        swm <= 1'b1;
        samp(12'h001);
        cmp("mode", MODE_STANDBY, mode);
        samp(12'hFFE);
        cmp("switch", 16'h1, sw);
        rd(8'h01, 8'h00);
        close_out();
    end
endmodule // testbench
